// *** logic/sfr_pkg.sv ***
// Package for the special-function register bank: offsets, fields, codes.
// Assumes a 32-bit register port with byte addresses.
package sfr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets
   localparam logic [7:0] OFS_CHIP_ID = 8'h00;
   localparam logic [7:0] OFS_CHIP_ID_EXT = 8'h04;
   localparam logic [7:0] OFS_RESET_CAUSE = 8'h08;
   localparam logic [7:0] OFS_PROTECT = 8'h18;

   ////////////////////////////////////////////////////////////////////////////
   // Identification field codes
   localparam logic [3:0] PNVM_NONE = 4'h0;
   localparam logic [3:0] PNVM_32K = 4'h3;
   localparam logic [3:0] PNVM_64K = 4'h5;
   localparam logic [3:0] PNVM_128K = 4'h7;
   localparam logic [3:0] PNVM_256K = 4'h9;
   localparam logic [3:0] DNVM_NONE = 4'h0;
   localparam logic [3:0] VMEM_NONE = 4'h0;
   localparam logic [3:0] VMEM_1K = 4'h1;
   localparam logic [3:0] VMEM_2K = 4'h2;
   localparam logic [3:0] VMEM_4K = 4'h4;
   localparam logic [3:0] VMEM_8K = 4'h8;
   localparam logic [2:0] PTYPE_MF = 3'h1;
   localparam logic [2:0] PTYPE_R = 3'h4;
   localparam logic [2:0] ID_FIXED_BITS = 3'h2;
   localparam logic [4:0] REV_MAX = 5'h1f;

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause codes and protect key
   localparam logic [7:0] CAUSE_PIN = 8'h6c;
   localparam logic [7:0] CAUSE_WATCHDOG = 8'h53;
   localparam logic [15:0] PROTECT_KEY = 16'h27a8;
   localparam int PROTECT_BIT = 5;
   localparam logic [31:0] PROTECT_RESET = 32'h00000000;

   // Identification word layout, msb first
   typedef struct packed {
      logic id_extension_flag;
      logic [2:0] program_nvm_type;
      logic [7:0] family_code;
      logic [3:0] volatile_mem_size;
      logic [3:0] data_nvm_size;
      logic [3:0] program_nvm_size;
      logic [2:0] fixedBits;
      logic [4:0] revision;
   } chip_id_t;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

endpackage : sfr_pkg

// *** logic/special_function_regs.sv ***
// Special-function register bank: chip id, id extension, reset cause and
// key-protected protect mode. Assumes a plain one-cycle register port and a
// reset-cause input that is stable when the chip reset is released.
//
// How it works
// - Five-bit revision field, hardwired, at most 31
// - Program memory size code from fixed table
// - Data nonvolatile size reads zero, none present
// - Volatile memory size is one-hot coded
// - Family code is two BCD digits
// - Program memory type hardwired three-bit code
// - Top id bit flags an extension word
// - Extension register at 0x04, read-only, zero
// - Reset cause 0x6c pin, 0x53 watchdog
// - Protect bit 5 drives interrupt controller mode
// - Key field always reads back zero
// - Protect write needs key 0x27a8, else ignored
`timescale 1ns/1ps
module special_function_regs #(
   parameter logic [4:0] REVISION = 5'h00,
   parameter logic [3:0] PNVM_SIZE = 4'h0,
   parameter logic [3:0] VMEM_SIZE = 4'h8,
   // Arbitrary family code, two BCD digits
   parameter logic [7:0] FAMILY_CODE = 8'h12,
   parameter logic [2:0] PNVM_TYPE = 3'h1,
   parameter logic ID_EXTENDED = 1'b0,
   // Arbitrary extension word contents
   parameter logic [31:0] ID_EXT_VALUE = 32'h00000000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic watchdogReset,
   output logic [31:0] rdata,
   output logic irq_ctrl_protect_enable
);

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte offsets
   // 0x00 identification word, hardwired
   // 0x04 identification extension, hardwired
   // 0x08 reset cause, low byte only
   // 0x0c to 0x14 unmapped, read zero
   // 0x18 protect mode, key in upper half
   // Other offsets unmapped, read zero
   // Writes to read-only offsets are dropped

   ////////////////////////////////////////////////////////////////////////////
   // Identification word layout, msb first
   // 31 extension flag
   // 30:28 program memory type
   // 27:20 family code, two BCD digits
   // 19:16 volatile memory size, one-hot
   // 15:12 data nonvolatile size, zero
   // 11:8 program memory size
   // 7:5 fixed pattern
   // 4:0 revision, one step per silicon spin

   ////////////////////////////////////////////////////////////////////////////
   // Address match against one register offset
   function automatic logic hitOffset(
      input logic [7:0] a,
      input logic [7:0] ofs
   );
      return a == ofs;
   endfunction : hitOffset

   // Upper half of a write holds the key
   function automatic logic keyMatches(
      input logic [31:0] d
   );
      return d[31:16] == sfr_pkg::PROTECT_KEY;
   endfunction : keyMatches

   // Revision kept inside its five-bit range
   function automatic logic [4:0] revField(
      input logic [4:0] code
   );
      return code & sfr_pkg::REV_MAX;
   endfunction : revField

   // Program memory size, reserved codes show none
   function automatic logic [3:0] pnvmField(
      input logic [3:0] code
   );
      logic [3:0] f;
      case (code)
         sfr_pkg::PNVM_NONE: begin
            f = code;
         end
         sfr_pkg::PNVM_32K: begin
            f = code;
         end
         sfr_pkg::PNVM_64K: begin
            f = code;
         end
         sfr_pkg::PNVM_128K: begin
            f = code;
         end
         sfr_pkg::PNVM_256K: begin
            f = code;
         end
         default: begin
            f = sfr_pkg::PNVM_NONE;
         end
      endcase

      return f;
   endfunction : pnvmField

   // Volatile memory size, one-hot or none
   function automatic logic [3:0] vmemField(
      input logic [3:0] code
   );
      logic [3:0] f;
      case (code)
         sfr_pkg::VMEM_NONE: begin
            f = code;
         end
         sfr_pkg::VMEM_1K: begin
            f = code;
         end
         sfr_pkg::VMEM_2K: begin
            f = code;
         end
         sfr_pkg::VMEM_4K: begin
            f = code;
         end
         sfr_pkg::VMEM_8K: begin
            f = code;
         end
         default: begin
            f = sfr_pkg::VMEM_NONE;
         end
      endcase

      return f;
   endfunction : vmemField

   // Program memory type, unknown codes show the default
   function automatic logic [2:0] ptypeField(
      input logic [2:0] code
   );
      logic [2:0] f;
      case (code)
         sfr_pkg::PTYPE_MF: begin
            f = code;
         end
         sfr_pkg::PTYPE_R: begin
            f = code;
         end
         default: begin
            f = sfr_pkg::PTYPE_MF;
         end
      endcase

      return f;
   endfunction : ptypeField

   // Family code, both digits must be decimal
   function automatic logic [7:0] familyField(
      input logic [7:0] code
   );
      logic [7:0] f;
      f = code;
      if (code[7:4] > 4'h9) begin
         f = 8'h00;
      end
      if (code[3:0] > 4'h9) begin
         f = 8'h00;
      end

      return f;
   endfunction : familyField

   // Reset cause code for the captured source
   function automatic logic [7:0] causeCode(
      input logic fromWatchdog
   );
      return fromWatchdog ? sfr_pkg::CAUSE_WATCHDOG
                          : sfr_pkg::CAUSE_PIN;
   endfunction : causeCode

   // Protect register read word, key field zero
   function automatic logic [31:0] protWord(
      input logic bitVal
   );
      logic [31:0] w;
      w = 32'h00000000;
      w[sfr_pkg::PROTECT_BIT] = bitVal;
      return w;
   endfunction : protWord

   ////////////////////////////////////////////////////////////////////////////
   // Legal field values, fixed at build time
   // Revision within range
   wire logic [4:0] revCode = revField(REVISION);
   // Program memory size from the table
   wire logic [3:0] pnvmCode = pnvmField(PNVM_SIZE);
   // Volatile memory size, one-hot
   wire logic [3:0] vmemCode = vmemField(VMEM_SIZE);
   // Program memory type, known series
   wire logic [2:0] ptypeCode = ptypeField(PNVM_TYPE);
   // Family code, two decimal digits
   wire logic [7:0] familyCode = familyField(FAMILY_CODE);

   ////////////////////////////////////////////////////////////////////////////
   // Hardwired identification word
   sfr_pkg::chip_id_t chipId;
   // Revision and fixed pattern
   assign chipId.revision = revCode;
   assign chipId.fixedBits = sfr_pkg::ID_FIXED_BITS;

   // Memory size fields
   assign chipId.program_nvm_size = pnvmCode;
   assign chipId.data_nvm_size = sfr_pkg::DNVM_NONE;
   assign chipId.volatile_mem_size = vmemCode;

   // Family, type and extension flag
   assign chipId.family_code = familyCode;
   assign chipId.program_nvm_type = ptypeCode;
   assign chipId.id_extension_flag = ID_EXTENDED;

   ////////////////////////////////////////////////////////////////////////////
   // Request bundle from the port
   sfr_pkg::reg_req_t req;
   assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

   // One select per mapped register
   wire selId = hitOffset(req.addr, sfr_pkg::OFS_CHIP_ID);
   wire selExt = hitOffset(req.addr, sfr_pkg::OFS_CHIP_ID_EXT);
   wire selCause = hitOffset(req.addr, sfr_pkg::OFS_RESET_CAUSE);
   wire selProt = hitOffset(req.addr, sfr_pkg::OFS_PROTECT);

   // Key check; only keyed protect writes land
   wire keyOk = keyMatches(req.wdata);
   wire protAddrWrite = req.wr && selProt;
   wire protWrite = protAddrWrite && keyOk;

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause, taken once after release
   logic [7:0] cause_r;
   logic [7:0] cause_nxt;
   logic causeTaken_r;

   // Code for the source of the last reset
   assign cause_nxt = causeCode(watchdogReset);

   // Cause register, frozen after the first capture
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cause_r <= sfr_pkg::CAUSE_PIN;
         causeTaken_r <= 1'b0;
      end else if (!causeTaken_r) begin
         causeTaken_r <= 1'b1;
         cause_r <= cause_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protect-mode bit
   logic protect_r;
   logic protect_nxt;
   // Keyed write takes bit 5, else hold
   assign protect_nxt = protWrite ? req.wdata[sfr_pkg::PROTECT_BIT]
                                  : protect_r;

   // Protect register, cleared by reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         protect_r <= sfr_pkg::PROTECT_RESET[sfr_pkg::PROTECT_BIT];
      end else begin
         protect_r <= protect_nxt;
      end
   end

   // Drive the interrupt controller mode
   assign irq_ctrl_protect_enable = protect_r;

   ////////////////////////////////////////////////////////////////////////////
   // Read words, one per register
   logic [31:0] idWord;
   logic [31:0] extWord;
   logic [31:0] causeWord;
   logic [31:0] protRead;

   // Word contents as software sees them
   assign idWord = chipId;
   assign extWord = ID_EXT_VALUE;
   assign causeWord = {24'h000000, cause_r};
   assign protRead = protWord(protect_r);

   ////////////////////////////////////////////////////////////////////////////
   // Read mux, unmapped reads zero
   logic [31:0] readMux;
   always_comb begin
      if (selId) begin
         readMux = idWord;
      end else if (selExt) begin
         readMux = extWord;
      end else if (selCause) begin
         readMux = causeWord;
      end else if (selProt) begin
         readMux = protRead;
      end else begin
         readMux = 32'h00000000;
      end
   end

   // Read data next value, zero without a strobe
   logic [31:0] rdata_nxt;
   assign rdata_nxt = req.rd ? readMux : 32'h00000000;

   // Read data valid the cycle after the strobe only
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Notes for users of this block
   // Reads never stall; data stands one cycle
   // Read and write in one cycle not supported
   // Protect writes touch bit 5 only
   // Key must come with every protect write
   // Unmapped writes are dropped without a sign
   // Reset cause needs its input settled at release
   // Cause stays frozen until the next reset
   // Extension word stays zero until defined
   // Reserved size codes never reach the id word
   // Family code must be two decimal digits
   // Id word fixed by the parameters above

endmodule : special_function_regs

// *** test/special_function_regs_assertions.sv ***
// Port checker for the special-function register bank.
// Assumes the default identification parameters of the bank.
`timescale 1ns/1ps
module special_function_regs_chk (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic watchdogReset,
   input wire logic [31:0] rdata,
   input wire logic irq_ctrl_protect_enable
);
   localparam logic [31:0] ID_WORD = 32'h11280040;
   localparam logic [7:0] PM = sfr_pkg::OFS_PROTECT;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   // Write to protect register carrying the right key
   sequence keyWrite;
      wr && addr == PM && wdata[31:16] == sfr_pkg::PROTECT_KEY;
   endsequence
   chk_id_word: assert property (
      rd && addr == 8'h00 |=> rdata == ID_WORD) else $error("id word");
   chk_ext_zero: assert property (
      rd && addr == 8'h04 |=> rdata == 32'h0) else $error("ext word");
   chk_cause_code: assert property (
      rd && addr == 8'h08 |=> rdata == 32'h6c || rdata == 32'h53)
      else $error("cause code");
   chk_key_zero: assert property (
      rd && addr == PM |=> rdata[31:16] == 16'h0) else $error("key read");
   chk_protect_read: assert property (
      rd && addr == PM |=> rdata[5] == irq_ctrl_protect_enable)
      else $error("protect read");
   chk_key_write: assert property (
      keyWrite |=> irq_ctrl_protect_enable == $past(wdata[5]))
      else $error("keyed write");
   chk_bad_key: assert property (
      !(wr && addr == PM && wdata[31:16] == sfr_pkg::PROTECT_KEY)
      |=> $stable(irq_ctrl_protect_enable)) else $error("protect changed");
   chk_idle_zero: assert property (
      !rd |=> rdata == 32'h0) else $error("rdata idle");
endmodule : special_function_regs_chk
bind special_function_regs special_function_regs_chk chk_i (.clk, .arst_n,
   .addr, .wdata, .wr, .rd, .watchdogReset, .rdata, .irq_ctrl_protect_enable);

// *** test/tb_special_function_regs.sv ***
// Self-checking bench for the special-function register bank.
// Assumes default parameters and a one-cycle register port.
`timescale 1ns/1ps
module tb_special_function_regs;
   logic clk = 0, arst_n = 0, wr = 0, rd = 0, watchdogReset = 0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic [31:0] rdata;
   logic irq_ctrl_protect_enable;
   int fail_count = 0, checks = 0;
   always #2.5 clk = ~clk;
   special_function_regs dut (.clk, .arst_n, .addr, .wdata, .wr, .rd,
      .watchdogReset, .rdata, .irq_ctrl_protect_enable);
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic write_reg(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : write_reg
   task automatic read_reg(string nm, logic [7:0] a, logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 check(nm, rdata, exp);
   endtask : read_reg
   task automatic do_reset(logic wd);
      watchdogReset <= wd;
      arst_n <= 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask : do_reset
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      do_reset(1'b0);
      read_reg("id", 8'h00, 32'h11280040);
      read_reg("ext", 8'h04, 32'h0);
      read_reg("cause", 8'h08, 32'h6c);
      write_reg(8'h18, 32'h27a90020);
      read_reg("protect", 8'h18, 32'h0);
      write_reg(8'h18, 32'h27a8ffff);
      #1 check("irq", 32'(irq_ctrl_protect_enable), 32'h1);
      read_reg("protect", 8'h18, 32'h20);
      for (int i = 0; i < 3; i++) write_reg(8'(4 * i), 32'hffffffff);
      read_reg("id", 8'h00, 32'h11280040);
      read_reg("ext", 8'h04, 32'h0);
      read_reg("cause", 8'h08, 32'h6c);
      read_reg("hole", 8'h0c, 32'h0);
      write_reg(8'h18, 32'h27a80000);
      #1 check("irq", 32'(irq_ctrl_protect_enable), 32'h0);
      do_reset(1'b1);
      read_reg("cause", 8'h08, 32'h53);
      read_reg("protect", 8'h18, 32'h0);
      report_and_stop();
   end
   // Hang guard
   initial begin
      #100000;
      fail_count++;
      report_and_stop();
   end
endmodule : tb_special_function_regs
